//--- duacfg_top.sv
// Purpose: per-channel mode registers and mode steering of a two-channel async serial controller
// Assumes: shift registers, fifos and bit clocks live outside; their status arrives on clk_i
// Notes: serial input and clear-to-send pins are synchronised here
`timescale 1ns/10ps
`include "duacfg_map.svh"

module duacfg_top
	import duacfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] serial_input_line_i,
	input wire logic [1:0] clear_to_send_in_n_i,
	input wire logic [1:0] tx_serial_i,
	input wire logic [1:0] tx_hold_empty_i,
	input wire logic [1:0] tx_shift_empty_i,
	input wire logic [1:0] bit_tick_i,
	input wire logic [1:0] rx_char_avail_i,
	input wire logic [1:0] rx_fifo_full_i,
	input wire logic [1:0][2:0] top_err_i,
	input wire logic [1:0] top_new_i,
	output logic [1:0] serial_output_line_o,
	output logic [1:0] rx_line_o,
	output logic [1:0] request_to_send_out_n_o,
	output logic [1:0] rx_irq_o,
	output logic [1:0] transmit_can_accept_o,
	output logic [1:0] transmit_all_empty_o,
	output duacfg_cfg_s [1:0] cfg_o
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// codes 8 and up land in the long range, so one field spans both stop ranges
	function automatic logic [5:0] stop_sixteenths(input logic [3:0] code, input logic [1:0] len);
		logic [5:0] base;
		logic [5:0] step;
		base = `DUACFG_STOP_SHORT_BASE;
		step = {2'b00, code};
		if (len == 2'b00 || code[3]) begin
			base = `DUACFG_STOP_LONG_BASE;
		end
		stop_sixteenths = base + step;
	endfunction

	function automatic logic par_active(input duacfg_parmode_e m);
		par_active = (m == PAR_WITH) || (m == PAR_FORCE);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	// channel select is one address bit, so both channels share one decoder

	logic take;
	logic hit;
	logic chan;
	logic [7:0] local_ofs;
	logic [7:0] mr1 [2];
	logic [7:0] mr2 [2];
	logic ptr_second [2];
	logic [2:0] err_char [2];
	logic [2:0] err_accum [2];
	logic rts_on [2];
	logic [1:0] drain_cnt [2];
	logic [1:0] rx_meta;
	logic [1:0] rx_sync;
	logic [1:0] cts_meta;
	logic [1:0] cts_sync_n;
	logic [7:0] stat_word [2];

	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign chan = wb_adr_i[`DUACFG_CHAN_BIT];
	// clearing the channel bit lets one offset compare serve both channels
	assign local_ofs = wb_adr_i & ~(8'h01 << `DUACFG_CHAN_BIT);
	assign hit = (wb_adr_i[`DUACFG_HIGH_MSB:`DUACFG_HIGH_LSB] == 3'h0);

	function automatic logic is_acc(input logic [7:0] ofs, input logic [7:0] want, input logic h);
		is_acc = h && (ofs == want);
	endfunction

	// status is built from the same gated flags that the pins show
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			duacfg_mr1_s m1;
			m1 = duacfg_mr1_s'(mr1[c]);
			stat_word[c] = 8'h00;
			stat_word[c][`DUACFG_ST_CHAR] = rx_char_avail_i[c];
			stat_word[c][`DUACFG_ST_FULL] = rx_fifo_full_i[c];
			stat_word[c][`DUACFG_ST_TRANSMIT_CAN_ACCEPT] = transmit_can_accept_o[c];
			stat_word[c][`DUACFG_ST_TRANSMIT_ALL_EMPTY] = transmit_all_empty_o[c];
			stat_word[c][`DUACFG_ST_IRQ] = rx_irq_o[c];
			stat_word[c][`DUACFG_ST_BRK:`DUACFG_ST_PAR] = m1.err_block ? err_accum[c] : err_char[c];
		end
	end

	// answer one cycle after the request; unmapped offsets read zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= take;
			wb_dat_o <= 32'h0;
			if (take && !wb_we_i) begin
				if (is_acc(local_ofs, `DUACFG_OFS_MODE, hit)) begin
					wb_dat_o[7:0] <= ptr_second[chan] ? mr2[chan] : mr1[chan];
				end else if (is_acc(local_ofs, `DUACFG_OFS_STAT, hit)) begin
					wb_dat_o[7:0] <= stat_word[chan];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode registers and pointer
	// a read of the first register advances the pointer too; sel only gates the data

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				mr1[c] <= `DUACFG_MR1_RESET;
				mr2[c] <= `DUACFG_MR2_RESET;
				ptr_second[c] <= 1'b0;
			end
		end else if (take) begin
			if (is_acc(local_ofs, `DUACFG_OFS_MODE, hit) && !ptr_second[chan]) begin
				ptr_second[chan] <= 1'b1;
				if (wb_we_i && wb_sel_i[0]) begin
					mr1[chan] <= wb_dat_i[7:0];
				end
			end
			if (is_acc(local_ofs, `DUACFG_OFS_MODE, hit) && ptr_second[chan] && wb_we_i && wb_sel_i[0]) begin
				mr2[chan] <= wb_dat_i[7:0];
			end
			if (is_acc(local_ofs, `DUACFG_OFS_CMD, hit) && wb_we_i && wb_sel_i[0] && wb_dat_i[`DUACFG_CMD_REWIND]) begin
				ptr_second[chan] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// both stages reset to marking so no false start bit follows reset

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta <= 2'h3;
			rx_sync <= 2'h3;
			cts_meta <= 2'h3;
			cts_sync_n <= 2'h3;
		end else begin
			rx_meta <= serial_input_line_i;
			rx_sync <= rx_meta;
			cts_meta <= clear_to_send_in_n_i;
			cts_sync_n <= cts_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error status: a new top character beats a same-cycle clear
	// parity flags mean nothing without parity, so they are masked there

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				err_char[c] <= 3'h0;
				err_accum[c] <= 3'h0;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				duacfg_mr1_s m1;
				duacfg_mr2_s m2;
				logic [2:0] seen;
				logic clr;
				m1 = duacfg_mr1_s'(mr1[c]);
				m2 = duacfg_mr2_s'(mr2[c]);
				clr = take && wb_we_i && wb_sel_i[0] && (chan == c[0]) && wb_dat_i[`DUACFG_CMD_ERRCLR]
					&& is_acc(local_ofs, `DUACFG_OFS_CMD, hit);
				seen = top_err_i[c] & {2'b11, par_active(m1.par_mode)} & {3{m2.ch_mode != CHMODE_REMOTE}};
				err_char[c] <= seen;
				err_accum[c] <= (clr ? 3'h0 : err_accum[c]) | (top_new_i[c] ? seen : 3'h0);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request-to-send; drain counts two ticks so at least one full bit passes
	// a set command beats any automatic negation in the same cycle

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				rts_on[c] <= 1'b0;
				drain_cnt[c] <= 2'h0;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				duacfg_mr1_s m1;
				duacfg_mr2_s m2;
				logic cmd;
				m1 = duacfg_mr1_s'(mr1[c]);
				m2 = duacfg_mr2_s'(mr2[c]);
				cmd = take && wb_we_i && wb_sel_i[0] && (chan == c[0]) && is_acc(local_ofs, `DUACFG_OFS_CMD, hit);
				if (!(tx_hold_empty_i[c] && tx_shift_empty_i[c]) || !rts_on[c]) begin
					drain_cnt[c] <= 2'h0;
				end else if (bit_tick_i[c] && drain_cnt[c] != `DUACFG_DRAIN_TICKS) begin
					drain_cnt[c] <= drain_cnt[c] + 2'h1;
				end
				if (cmd && wb_dat_i[`DUACFG_CMD_RTSSET]) begin
					rts_on[c] <= 1'b1;
				end else if (cmd && wb_dat_i[`DUACFG_CMD_RTSCLR]) begin
					rts_on[c] <= 1'b0;
				end else if (m1.rx_rts_ctl && rx_fifo_full_i[c]) begin
					rts_on[c] <= 1'b0;
				end else if (m2.tx_rts_ctl && drain_cnt[c] == `DUACFG_DRAIN_TICKS) begin
					rts_on[c] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode steering outputs
	// every output is a flop, so pin to line costs three cycles in echo and remote loop modes

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_output_line_o <= 2'h3;
			rx_line_o <= 2'h3;
			request_to_send_out_n_o <= 2'h3;
			rx_irq_o <= 2'h0;
			transmit_can_accept_o <= 2'h0;
			transmit_all_empty_o <= 2'h0;
			cfg_o <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				duacfg_mr1_s m1;
				duacfg_mr2_s m2;
				logic tx_on_line;
				m1 = duacfg_mr1_s'(mr1[c]);
				m2 = duacfg_mr2_s'(mr2[c]);
				tx_on_line = (m2.ch_mode == CHMODE_NORMAL) || (m2.ch_mode == CHMODE_LOCAL);
				request_to_send_out_n_o[c] <= ~rts_on[c];
				rx_irq_o[c] <= m1.rx_irq_full ? rx_fifo_full_i[c] : rx_char_avail_i[c];
				case (m2.ch_mode)
					CHMODE_NORMAL: begin
						serial_output_line_o[c] <= tx_serial_i[c];
						rx_line_o[c] <= rx_sync[c];
					end
					CHMODE_ECHO: begin
						serial_output_line_o[c] <= rx_sync[c];
						rx_line_o[c] <= rx_sync[c];
					end
					CHMODE_LOCAL: begin
						serial_output_line_o[c] <= 1'b1;
						rx_line_o[c] <= tx_serial_i[c];
					end
					CHMODE_REMOTE: begin
						serial_output_line_o[c] <= rx_sync[c];
						rx_line_o[c] <= rx_sync[c];
					end
					default: begin
						serial_output_line_o[c] <= 1'b1;
						rx_line_o[c] <= rx_sync[c];
					end
				endcase
				// remote loop also hides transmit status; the cpu has no transmit path there
				// status held inactive
				transmit_can_accept_o[c] <= tx_on_line & tx_hold_empty_i[c];
				transmit_all_empty_o[c] <= tx_on_line & tx_hold_empty_i[c] & tx_shift_empty_i[c];
				cfg_o[c].data_bits <= `DUACFG_DATA_BASE + {2'b00, m1.char_len};
				cfg_o[c].par_mode <= m1.par_mode;
				cfg_o[c].par_type <= m1.par_type;
				cfg_o[c].par_generate <= par_active(m1.par_mode) && tx_on_line;
				cfg_o[c].par_check <= par_active(m1.par_mode) && (m2.ch_mode != CHMODE_REMOTE);
				cfg_o[c].stop_sixteenths <= stop_sixteenths(m2.stop_len, m1.char_len);
				cfg_o[c].tx_may_start <= ~m2.cts_enable | ~cts_sync_n[c];
				cfg_o[c].rx_clk_from_tx <= (m2.ch_mode == CHMODE_LOCAL);
				cfg_o[c].tx_force_on <= (m2.ch_mode == CHMODE_LOCAL);
				cfg_o[c].tx_cpu_en <= tx_on_line;
				cfg_o[c].rx_cpu_en <= (m2.ch_mode != CHMODE_REMOTE);
			end
		end
	end

endmodule // duacfg_top

//--- duacfg_map.svh
// Purpose: offsets, field positions, commands and reset values of the channel mode block
// Assumes: byte-addressed classic Wishbone, 32-bit data, one aligned word per register
// Notes: channel b sits one stride above channel a
`ifndef DUACFG_MAP_SVH
`define DUACFG_MAP_SVH

`define DUACFG_OFS_MODE 8'h00
`define DUACFG_OFS_STAT 8'h04
`define DUACFG_OFS_CMD 8'h08
`define DUACFG_CHAN_BIT 4
`define DUACFG_HIGH_MSB 7
`define DUACFG_HIGH_LSB 5

`define DUACFG_MR1_RESET 8'h00
`define DUACFG_MR2_RESET 8'h00

`define DUACFG_CMD_REWIND 0
`define DUACFG_CMD_ERRCLR 1
`define DUACFG_CMD_RTSSET 2
`define DUACFG_CMD_RTSCLR 3

`define DUACFG_ST_CHAR 0
`define DUACFG_ST_FULL 1
`define DUACFG_ST_TRANSMIT_CAN_ACCEPT 2
`define DUACFG_ST_TRANSMIT_ALL_EMPTY 3
`define DUACFG_ST_IRQ 4
`define DUACFG_ST_PAR 5
`define DUACFG_ST_FRM 6
`define DUACFG_ST_BRK 7

`define DUACFG_STOP_SHORT_BASE 6'h09
`define DUACFG_STOP_LONG_BASE 6'h11
`define DUACFG_DATA_BASE 4'h5
`define DUACFG_DRAIN_TICKS 2'h2

`endif

//--- duacfg_pkg.sv
// Purpose: types shared by the channel mode block
// Assumes: field layout of the two mode registers as packed structs
// Notes: none
package duacfg_pkg;

	typedef enum logic [1:0] {
		CHMODE_NORMAL = 2'b00,
		CHMODE_ECHO = 2'b01,
		CHMODE_LOCAL = 2'b10,
		CHMODE_REMOTE = 2'b11
	} duacfg_chmode_e;

	typedef enum logic [1:0] {
		PAR_WITH = 2'b00,
		PAR_FORCE = 2'b01,
		PAR_NONE = 2'b10,
		PAR_MULTIDROP = 2'b11
	} duacfg_parmode_e;

	typedef struct packed {
		logic rx_rts_ctl;
		logic rx_irq_full;
		logic err_block;
		duacfg_parmode_e par_mode;
		logic par_type;
		logic [1:0] char_len;
	} duacfg_mr1_s;

	typedef struct packed {
		duacfg_chmode_e ch_mode;
		logic tx_rts_ctl;
		logic cts_enable;
		logic [3:0] stop_len;
	} duacfg_mr2_s;

	typedef struct packed {
		logic [3:0] data_bits;
		duacfg_parmode_e par_mode;
		logic par_type;
		logic par_generate;
		logic par_check;
		logic [5:0] stop_sixteenths;
		logic tx_may_start;
		logic rx_clk_from_tx;
		logic tx_force_on;
		logic tx_cpu_en;
		logic rx_cpu_en;
	} duacfg_cfg_s;

endpackage

//--- duacfg_top_monitor.sv
// Purpose: port checks of the channel mode block, channel a
// Assumes: one clock, synchronous reset
// Notes: channel b shares the logic and is left to the bench
`timescale 1ns/10ps
module duacfg_top_monitor
	import duacfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] clear_to_send_in_n_i,
	input wire logic [1:0] tx_serial_i,
	input wire logic [1:0] serial_output_line_o,
	input wire logic [1:0] rx_line_o,
	input wire logic [1:0] transmit_can_accept_o,
	input wire logic [1:0] transmit_all_empty_o,
	input wire duacfg_cfg_s [1:0] cfg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	duacfg_cfg_s c;
	assign c = cfg_o[0];
	////////////////////////////////////////////////////////////////
	chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack is not a one cycle answer");
	chk_loop_out_mark: assert property (c.tx_force_on && $past(c.tx_force_on) |-> serial_output_line_o[0])
		else $error("loop output not marking");
	chk_loop_rx_feed: assert property (c.rx_clk_from_tx && $past(c.rx_clk_from_tx) |-> rx_line_o[0] == $past(tx_serial_i[0]))
		else $error("receiver not fed from transmitter");
	chk_echo_tx_quiet: assert property ($stable(c) && !c.tx_cpu_en && c.rx_cpu_en |-> !transmit_can_accept_o[0] && !transmit_all_empty_o[0])
		else $error("echo shows transmit status");
	chk_echo_no_gen: assert property (!c.tx_cpu_en && c.rx_cpu_en |-> !c.par_generate)
		else $error("echo generates parity");
	chk_remote_no_check: assert property (!c.rx_cpu_en |-> !c.par_check)
		else $error("remote loop checks parity");
	chk_len_stop_range: assert property (!$past(rst_i) |-> c.data_bits inside {[5:8]} && c.stop_sixteenths inside {[9:32]} && (c.data_bits != 5 || c.stop_sixteenths >= 17))
		else $error("length or stop out of range");
	chk_cts_gate_start: assert property (!$past(rst_i) && !c.tx_may_start |-> $past(clear_to_send_in_n_i[0], 3))
		else $error("start blocked with clear to send low");
	chk_par_gen_mode: assert property (c.par_generate |-> c.par_mode inside {PAR_WITH, PAR_FORCE})
		else $error("parity generated in wrong mode");
endmodule // duacfg_top_monitor

//--- duacfg_far_end.sv
// Purpose: far-end async transmitter on channel a serial input, plus clear-to-send
// Assumes: fixed bit time, 8 data bits, no parity, one stop bit
// Notes: line marks between frames; channel b stays idle
`timescale 1ns/10ps
module duacfg_far_end #(
	parameter int BIT_CLKS = 4
) (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [7:0] data_i,
	input wire logic cts_low_i,
	output logic [1:0] line_o,
	output logic [1:0] cts_n_o
);
	logic [9:0] sh = 10'h3FF;
	int cnt = 0;
	int left = 0;
	assign line_o = {1'b1, sh[0]};
	assign cts_n_o = {1'b1, !cts_low_i};
	// shifting ones in keeps the line marking once the frame is out
	always @(posedge clk_i) begin
		if (left == 0 && send_i) begin
			sh <= {1'b1, data_i, 1'b0};
			left <= 10;
			cnt <= BIT_CLKS;
		end else if (left != 0) begin
			cnt <= (cnt == 1) ? BIT_CLKS : cnt - 1;
			if (cnt == 1) begin
				sh <= {1'b1, sh[9:1]};
				left <= left - 1;
			end
		end
	end
endmodule // duacfg_far_end

//--- duacfg_top_tb.sv
// Purpose: self-checking bench of the channel mode block
// Assumes: classic wishbone master, far-end model on channel a
// Notes: expectations come from a small register model here
`timescale 1ns/10ps
module duacfg_top_tb;
	import duacfg_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ctl = 0, snd = 0;
	logic [7:0] adr = 0;
	logic [31:0] dw = 0, dat, rd, seed = 32'hB58A76D6;
	logic [1:0] txs = 2'h3, he = 0, se = 0, tk = 0, ca = 0, ff = 0, tn = 0, pin, cts, so, rl, rts, irq, tca, tae;
	logic [1:0][2:0] te = 0;
	logic [2:0] hp = 0;
	logic tl = 0;
	duacfg_cfg_s [1:0] cfg;
	duacfg_cfg_s c;
	logic [7:0] mr[2][2] = '{default: 8'h00};
	int ptr[2] = '{default: 0};
	int errors = 0, checks_done = 0, l, k;
	always #10 clk_i = ~clk_i;
	duacfg_top i_duacfg_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dw), .wb_sel_i(4'hF), .wb_dat_o(dat), .wb_ack_o(ack), .serial_input_line_i(pin),
		.clear_to_send_in_n_i(cts), .tx_serial_i(txs), .tx_hold_empty_i(he), .tx_shift_empty_i(se),
		.bit_tick_i(tk), .rx_char_avail_i(ca), .rx_fifo_full_i(ff), .top_err_i(te), .top_new_i(tn),
		.serial_output_line_o(so), .rx_line_o(rl), .request_to_send_out_n_o(rts), .rx_irq_o(irq),
		.transmit_can_accept_o(tca), .transmit_all_empty_o(tae), .cfg_o(cfg));
	duacfg_far_end i_duacfg_far_end (.clk_i, .send_i(snd), .data_i(seed[15:8]), .cts_low_i(ctl), .line_o(pin),
		.cts_n_o(cts));
	////////////////////////////////////////////////////////////////
	task complete_run;
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dw <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = dat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic mw(input int ch, input logic w, input logic [7:0] d);
		wb(w, 8'(ch * 16), d);
		if (!w) chk(rd, {24'h0, mr[ch][ptr[ch]]});
		else mr[ch][ptr[ch]] = d;
		ptr[ch] = 1;
	endtask
	task automatic cmd(input int ch, input logic [7:0] d);
		wb(1, 8'(ch * 16 + 8), d);
		if (d[0]) ptr[ch] = 0;
	endtask
	// every mode set reads the second register back to prove the pointer holds
	task automatic setm(input int ch, input logic [7:0] a, input logic [7:0] b);
		cmd(ch, 8'h01);
		mw(ch, 1, a);
		mw(ch, 1, b);
		mw(ch, 0, 0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		mw(0, 0, 0);
		mw(0, 0, 0);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			ctl <= seed[13];
			setm(i % 2, seed[7:0], {3'h0, seed[12:8]});
			c = cfg[i % 2];
			l = seed[1:0];
			k = seed[11:8];
			chk(c.data_bits, 5 + l);
			chk(c.par_mode, seed[4:3]);
			chk(c.par_type, seed[2]);
			chk(c.par_generate, !seed[4]);
			chk(c.stop_sixteenths, l == 0 || k > 7 ? 17 + k : 9 + k);
			chk(c.tx_may_start, !seed[12] || (seed[13] && i % 2 == 0));
		end
		he <= 2'h3;
		se <= 2'h3;
		snd <= 1;
		for (int m = 0; m < 4; m++) begin
			setm(0, 8'h00, {m[1:0], 6'h00});
			for (int j = 0; j < 60; j++) begin
				@(posedge clk_i);
				if (j > 4) chk(so[0], m == 2 ? 1 : m == 0 ? tl : hp[2]);
				if (j > 4) chk(rl[0], m == 2 ? tl : hp[2]);
				hp = {hp[1:0], pin[0]};
				tl = txs[0];
				seed = xs(seed);
				txs <= seed[1:0];
			end
			c = cfg[0];
			chk(c.tx_cpu_en, !m[0]);
			chk(c.rx_cpu_en, m != 3);
			chk(c.rx_clk_from_tx, m == 2);
			chk(c.par_generate, !m[0]);
			chk({tca[0], tae[0]}, m[0] ? 0 : 3);
			chk(c.par_check, m != 3);
			chk(c.tx_force_on, m == 2);
		end
		snd <= 0;
		ca <= 2'h1;
		for (int s = 0; s < 4; s++) begin
			setm(0, {1'b1, s[0], 6'h00}, 8'h00);
			ff <= {1'b0, s[1]};
			cmd(0, 8'h04);
			repeat (3) @(posedge clk_i);
			chk(irq[0], s[0] ? s[1] : 1);
			chk(rts[0], s[1]);
		end
		for (int b = 0; b < 2; b++) begin
			setm(0, {2'b00, b[0], 5'h00}, 8'h00);
			cmd(0, 8'h02);
			te <= 6'h05;
			tn <= 2'h1;
			@(posedge clk_i);
			te <= 6'h02;
			@(posedge clk_i);
			tn <= 0;
			repeat (2) @(posedge clk_i);
			wb(0, 8'h04, 0);
			chk(rd[7:5], b ? 7 : 2);
			cmd(0, 8'h02);
			wb(0, 8'h04, 0);
			chk(rd[7:5], b ? 0 : 2);
		end
		setm(0, 8'h00, 8'h20);
		cmd(0, 8'h04);
		repeat (4) @(posedge clk_i);
		chk(rts[0], 0);
		repeat (2) begin
			tk <= 2'h1;
			@(posedge clk_i);
			tk <= 0;
			repeat (2) @(posedge clk_i);
		end
		repeat (2) @(posedge clk_i);
		chk(rts[0], 1);
		cmd(0, 8'h04);
		chk(rts[0], 0);
		cmd(0, 8'h08);
		chk(rts[0], 1);
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run;
	end
endmodule // duacfg_top_tb
bind duacfg_top duacfg_top_monitor i_duacfg_top_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.clear_to_send_in_n_i, .tx_serial_i, .serial_output_line_o, .rx_line_o, .transmit_can_accept_o,
	.transmit_all_empty_o, .cfg_o);
